// *** verilog/syd_pkg.sv ***
// constants shared by the sync activity block and its pulse monitor
// assumes a single 20 MHz clock and an AXI4-Lite master for register access
package syd_pkg;
    // clock
    localparam int unsigned CLK_HZ = 20000000;
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_POLARITY = 6'h02;
    localparam logic [5:0] IDX_SLICER = 6'h04;
    localparam logic [5:0] IDX_INCFG = 6'h05;
    // reset values
    localparam logic [7:0] SLICER_RST = 8'h16;
    localparam logic [7:0] INCFG_RST = 8'h00;
    // field positions
    localparam int SLICER_LPF_BIT = 4;
    localparam int INCFG_CH_BIT = 0;
    localparam int INCFG_SRC_LSB = 3;
    localparam int STAT_TRI_BIT = 6;
    localparam int STAT_COMP_BIT = 7;
    // monitor slots: line 1:0, frame 3:2, green 5:4, trilevel 7:6
    localparam int NUM_MON = 8;
    localparam int MON_LINE = 0;
    localparam int MON_FRAME = 2;
    localparam int MON_GREEN = 4;
    localparam int MON_TRI = 6;
    localparam logic [7:0] STRICT_MASK = 8'h30;
    // sync source select in the input configuration register
    typedef enum logic [1:0] {
        SYD_SRC_SEPARATE = 2'b00,
        SYD_SRC_COMP_LINE = 2'b01,
        SYD_SRC_GREEN = 2'b10,
        SYD_SRC_GREEN_ALT = 2'b11
    } syd_src_t;
    // timing
    localparam int CNT_W = 12;
    localparam int unsigned IDLE_US = 200;
    localparam logic [11:0] IDLE_CYC = 12'(IDLE_US * (CLK_HZ / 1000000));
    localparam logic [6:0] RUN_LEN = 7'd64;
    localparam logic [11:0] PULSE_TOL = 12'd2;
    localparam int unsigned LPF_NS = 100;
    localparam logic [1:0] LPF_CYC = 2'((LPF_NS * (CLK_HZ / 1000000) + 999) / 1000);
    localparam int unsigned LONG_PULSE_NS = 10000;
    localparam logic [11:0] LONG_CYC = 12'(LONG_PULSE_NS / (1000000000 / CLK_HZ));
    localparam int unsigned COMP_WINDOW_MS = 50;
    localparam int unsigned COMP_WINDOW_CYC = COMP_WINDOW_MS * (CLK_HZ / 1000);
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** verilog/syd_mon_if.sv ***
// carrier between the sync block top and its pulse monitor
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface syd_mon_if;
    logic [7:0] level;
    logic [7:0] active;
    logic [7:0] polarity;
    logic [6:0] run_green0;
    modport mon (input level, output active, output polarity, output run_green0);
    modport user (output level, input active, input polarity, input run_green0);
endinterface
`default_nettype wire

// *** verilog/syd_sync_mon.sv ***
// pulse activity and polarity monitor for eight synchronised sync levels
// assumes levels arrive already synchronised to aclk
`timescale 1ns/10ps
`default_nettype none
module syd_sync_mon (
    input wire logic aclk,
    input wire logic aresetn,
    syd_mon_if.mon mon
);
    typedef struct packed {
        logic [7:0] prev;
        logic [7:0][11:0] hi_cnt;
        logic [7:0][11:0] per_cnt;
        logic [7:0][11:0] last_hi;
        logic [7:0][11:0] last_per;
        logic [7:0][6:0] run;
        logic [7:0] active;
        logic [7:0] pol;
    } syd_mon_state_t;

    syd_mon_state_t q, d;

    // sampling jitter of an async edge is one cycle each side, hence a tolerance
    function automatic logic syd_near(input logic [11:0] a, input logic [11:0] b);
        return ((a > b) ? (a - b) : (b - a)) <= syd_pkg::PULSE_TOL;
    endfunction

    // per slot: measure period and high time, count matching pulses, time out idle
    always_comb
    begin
        logic match;
        match = 1'b0;
        d = q;
        d.prev = mon.level;
        for (int k = 0; k < syd_pkg::NUM_MON; k++)
        begin
            if (q.per_cnt[k] != syd_pkg::IDLE_CYC)
            begin
                d.per_cnt[k] = q.per_cnt[k] + 12'd1;
            end
            if (mon.level[k] && q.hi_cnt[k] != syd_pkg::IDLE_CYC)
            begin
                d.hi_cnt[k] = q.hi_cnt[k] + 12'd1;
            end
            if (mon.level[k] && !q.prev[k])
            begin
                match = syd_near(q.per_cnt[k], q.last_per[k]) && syd_near(q.hi_cnt[k], q.last_hi[k]);
                d.run[k] = !match ? 7'd1 : (q.run[k] == syd_pkg::RUN_LEN) ? q.run[k] : q.run[k] + 7'd1;
                // strict slots need the full run of equal pulses, others one pulse R9 R11
                d.active[k] = syd_pkg::STRICT_MASK[k] ? (d.run[k] == syd_pkg::RUN_LEN) : 1'b1;
                // mostly high means the sync pulse itself is the low part
                d.pol[k] = q.hi_cnt[k] > (q.per_cnt[k] - q.hi_cnt[k]); // R1
                d.last_per[k] = q.per_cnt[k];
                d.last_hi[k] = q.hi_cnt[k];
                d.per_cnt[k] = 12'd0;
                d.hi_cnt[k] = 12'd0;
            end
            else if (q.per_cnt[k] == syd_pkg::IDLE_CYC)
            begin
                d.active[k] = 1'b0; // R1
                d.run[k] = 7'd0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign mon.active = q.active;
    assign mon.polarity = q.pol;
    assign mon.run_green0 = q.run[syd_pkg::MON_GREEN];

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_green_run_len: assert property ($rose(q.active[4]) |-> $past(q.run[4]) == 7'd63) // R9
        else $error("green activity set before 64 matching pulses");
    a_tri_quick_set: assert property (mon.level[6] && !q.prev[6] |=> q.active[6]) // R11
        else $error("trilevel detect not set on first pulse");
    // a fresh edge in the timeout cycle legally re-arms the slot, so it is left out
    a_idle_clears: assert property (q.per_cnt[0] == syd_pkg::IDLE_CYC // R1
        && !(mon.level[0] && !q.prev[0]) |=> !q.active[0])
        else $error("line activity held after idle timeout");
endmodule
`default_nettype wire

// *** verilog/syd_sync_top.sv ***
// sync activity, polarity and type detection with sync pass-through and markers
// assumes an AXI4-Lite master on aclk; sync pins are asynchronous to aclk
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1 - all six sync inputs are watched; activity and polarity readable in two registers
// R2 - firmware walks the source table in order, stopping at first match
// R3 - line and frame both active means separate sync
// R4 - line only active: firmware selects composite on line and checks present bit
// R5 - only green active means composite on green; trilevel bit hints trilevel
// R6 - no line, frame or green activity means no valid source
// R7 - firmware confirms composite sources by selecting them and reading present bit
// R8 - firmware prefers line and frame activity over green activity
// R9 - green activity sets only after 64 equal pulses of same period and duty
// R10 - firmware trusts green activity only while line activity is clear
// R11 - trilevel detect sets without any run of pulses
// R12 - firmware trusts trilevel only with line clear and green set
// R13 - firmware polls trilevel several times; any one reads as likely
// R14 - composite present sets on slow repeating long pulses within chosen source
// R15 - firmware keeps the green low pass filter enabled
// R16 - pass-through sync outputs are plain copies, never resampled
// R17 - line and frame markers come from clocked logic; line marker starts lines
// R18 - detectors and pass-through keep running in power down
// R19 - pass-through line output copies selected line or green input unchanged
// R20 - green selection passes the whole embedded waveform to line output
// R21 - status bits follow live detection; reads have no side effect
module syd_sync_top #(
    parameter int unsigned COMP_WINDOW_CYC = syd_pkg::COMP_WINDOW_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] line_sync_in,
    input wire logic [1:0] frame_sync_in,
    input wire logic [1:0] green_embedded_sync_input,
    input wire logic [1:0] trilevel_in,
    input wire logic power_down,
    output logic line_sync_out,
    output logic frame_sync_out,
    output logic line_start_marker,
    output logic frame_marker
);
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic pd1;
        logic pd2;
        logic [1:0][1:0] lpf_cnt;
        logic [1:0] green_f;
        logic sel_prev;
        logic line_mark;
        logic frame_mark;
        logic [11:0] cw;
        logic [31:0] cwin;
        logic comp_seen;
        logic comp_present;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] slicer_cfg;
        logic [7:0] in_cfg;
    } syd_top_state_t;

    syd_top_state_t q, d;
    syd_mon_if mon_bus ();
    logic ch;
    syd_pkg::syd_src_t src;
    logic src_green;
    logic comp_sel;
    logic sel_norm;
    logic frame_norm;
    logic [7:0] status;

    // word address match; upper address bits must be zero
    function automatic logic syd_hit(input logic [7:0] addr, input logic [5:0] idx);
        return addr[7:2] == idx;
    endfunction

    // map of readable registers, unmapped words flag an error
    function automatic logic syd_mapped(input logic [7:0] addr);
        return syd_hit(addr, syd_pkg::IDX_STATUS) || syd_hit(addr, syd_pkg::IDX_POLARITY) ||
            syd_hit(addr, syd_pkg::IDX_SLICER) || syd_hit(addr, syd_pkg::IDX_INCFG);
    endfunction

    syd_sync_mon u_mon (
        .aclk(aclk),
        .aresetn(aresetn),
        .mon(mon_bus.mon)
    );

    // source selection from the input configuration register
    assign ch = q.in_cfg[syd_pkg::INCFG_CH_BIT];
    assign src = syd_pkg::syd_src_t'(q.in_cfg[syd_pkg::INCFG_SRC_LSB +: 2]);
    assign src_green = (src == syd_pkg::SYD_SRC_GREEN) || (src == syd_pkg::SYD_SRC_GREEN_ALT);
    assign comp_sel = src != syd_pkg::SYD_SRC_SEPARATE;

    // pass-through is pure muxing of the pins, no flop, so width and jitter survive
    assign line_sync_out = src_green ? green_embedded_sync_input[ch] : line_sync_in[ch]; // R16 R19 R20
    assign frame_sync_out = frame_sync_in[ch]; // R16

    // monitor feeds: green goes through the optional low pass filter
    assign mon_bus.level = {q.s2[7:6], q.green_f, q.s2[3:0]}; // R1 R18

    // selected line-type source and frame source, folded to active high
    assign sel_norm = src_green ? (q.green_f[ch] ^ mon_bus.polarity[syd_pkg::MON_GREEN + ch])
        : (q.s2[syd_pkg::MON_LINE + ch] ^ mon_bus.polarity[syd_pkg::MON_LINE + ch]);
    assign frame_norm = q.s2[syd_pkg::MON_FRAME + ch] ^ mon_bus.polarity[syd_pkg::MON_FRAME + ch];

    // status is read live from the monitor, nothing latches on a read
    assign status = {q.comp_present, mon_bus.active[syd_pkg::MON_TRI + ch],
        mon_bus.active[5:0]}; // R1 R21

    // one combined next-state process: sync, filter, markers, composite, registers
    always_comb
    begin
        d = q;
        // two-flop synchronisers; s1 is read by s2 only
        d.s1 = {trilevel_in, green_embedded_sync_input, frame_sync_in, line_sync_in};
        d.s2 = q.s1;
        d.pd1 = power_down;
        d.pd2 = q.pd1;
        // green filter: a level must persist before it is accepted
        for (int c = 0; c < 2; c++)
        begin
            if (!q.slicer_cfg[syd_pkg::SLICER_LPF_BIT] || q.s2[syd_pkg::MON_GREEN + c] == q.green_f[c])
            begin
                d.lpf_cnt[c] = 2'd0;
                d.green_f[c] = q.s2[syd_pkg::MON_GREEN + c];
            end
            else if (q.lpf_cnt[c] == syd_pkg::LPF_CYC - 2'd1)
            begin
                d.lpf_cnt[c] = 2'd0;
                d.green_f[c] = q.s2[syd_pkg::MON_GREEN + c];
            end
            else
            begin
                d.lpf_cnt[c] = q.lpf_cnt[c] + 2'd1;
            end
        end
        // markers idle in power down; trailing edge of sync starts a line
        d.sel_prev = sel_norm;
        d.line_mark = q.sel_prev && !sel_norm && !q.pd2; // R17
        d.frame_mark = frame_norm && !q.pd2; // R17
        // composite present: long pulses inside the line-type source, repeating
        if (!comp_sel)
        begin
            d.cw = 12'd0;
            d.cwin = 32'd0;
            d.comp_seen = 1'b0;
            d.comp_present = 1'b0;
        end
        else
        begin
            if (sel_norm && q.cw != syd_pkg::LONG_CYC)
            begin
                d.cw = q.cw + 12'd1;
            end
            else if (!sel_norm)
            begin
                d.cw = 12'd0;
            end
            if (q.sel_prev && !sel_norm && q.cw == syd_pkg::LONG_CYC)
            begin
                d.comp_present = q.comp_seen; // R14
                d.comp_seen = 1'b1;
                d.cwin = 32'd0;
            end
            else if (q.cwin == COMP_WINDOW_CYC - 1)
            begin
                d.comp_present = 1'b0; // R14
                d.comp_seen = 1'b0;
                d.cwin = 32'd0;
            end
            else
            begin
                d.cwin = q.cwin + 32'd1;
            end
        end
        // write path: address and data in either order, response after both
        if (s_axi_awvalid && s_axi_awready)
        begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata[7:0];
            d.wstrb0 = s_axi_wstrb[0];
        end
        if (q.aw_got && q.w_got)
        begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = syd_mapped(q.awaddr) ? syd_pkg::RESP_OKAY : syd_pkg::RESP_SLVERR;
            // status words are read-only, writes to them are dropped silently
            if (q.wstrb0 && syd_hit(q.awaddr, syd_pkg::IDX_SLICER))
            begin
                d.slicer_cfg = q.wdata;
            end
            if (q.wstrb0 && syd_hit(q.awaddr, syd_pkg::IDX_INCFG))
            begin
                d.in_cfg = q.wdata;
            end
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end
        // read path: data captured at the address handshake
        if (s_axi_arvalid && s_axi_arready)
        begin
            d.rvalid = 1'b1;
            d.rresp = syd_mapped(s_axi_araddr) ? syd_pkg::RESP_OKAY : syd_pkg::RESP_SLVERR;
            d.rdata = 32'h00000000;
            if (syd_hit(s_axi_araddr, syd_pkg::IDX_STATUS))
            begin
                d.rdata[7:0] = status; // R21
            end
            else if (syd_hit(s_axi_araddr, syd_pkg::IDX_POLARITY))
            begin
                d.rdata[7:0] = {2'b00, mon_bus.polarity[5:0]}; // R1
            end
            else if (syd_hit(s_axi_araddr, syd_pkg::IDX_SLICER))
            begin
                d.rdata[7:0] = q.slicer_cfg;
            end
            else if (syd_hit(s_axi_araddr, syd_pkg::IDX_INCFG))
            begin
                d.rdata[7:0] = q.in_cfg;
            end
        end
        else if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
    end

    // register the whole state; configuration resets to its defaults
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.slicer_cfg <= syd_pkg::SLICER_RST;
            q.in_cfg <= syd_pkg::INCFG_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // bus handshakes: one write and one read outstanding at most
    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign line_start_marker = q.line_mark;
    assign frame_marker = q.frame_mark;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_green_whole_wave: assert property (src_green |-> line_sync_out == green_embedded_sync_input[ch]) // R20
        else $error("green waveform not on line output");
    a_pd_passthru: assert property (q.pd2 && !src_green |-> line_sync_out == line_sync_in[ch]) // R18 R16
        else $error("pass-through lost in power down");
    a_marker_single: assert property (line_start_marker |=> !line_start_marker) // R17
        else $error("line marker longer than one cycle");
    a_marker_cause: assert property (line_start_marker |-> $past(q.sel_prev) && !q.sel_prev) // R17
        else $error("line marker without trailing sync edge");
    a_comp_needs_src: assert property (q.comp_present |-> $past(comp_sel)) // R14
        else $error("composite present with separate source");
    a_comp_two_long: assert property ($rose(q.comp_present) |-> $past(q.comp_seen)) // R14
        else $error("composite present after single long pulse");
    a_status_read: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 8'h04 |=> s_axi_rvalid && s_axi_rdata[5:0] == $past(mon_bus.active[5:0])) // R1 R21
        else $error("status read does not show live activity");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
endmodule
`default_nettype wire

// *** dv/syd_sync_src.sv ***
// partner model: the analog side sync source, one pulse train shared by enabled lines
// assumes aclk from the bench; lines move just after the rising edge
`timescale 1ns/10ps
`default_nettype none
module syd_sync_src (
    input wire logic aclk,
    input wire logic [7:0] run,
    input wire logic [7:0] inv,
    input wire logic [11:0] period,
    input wire logic [11:0] width,
    output logic [1:0] line_sync,
    output logic [1:0] frame_sync,
    output logic [1:0] green_sync,
    output logic [1:0] tri_sync
);
    logic [11:0] cnt_q = 12'h000;
    logic [7:0] lvl;
    // free running phase; a shorter period must not strand the count
    always_ff @(posedge aclk)
    begin
        cnt_q <= (cnt_q + 12'h001 >= period) ? 12'h000 : cnt_q + 12'h001;
    end
    // stopped lines rest at idle level, never at a held pulse
    always_comb
    begin
        lvl = (run & {8{cnt_q < width}}) ^ inv;
    end
    assign {tri_sync, green_sync, frame_sync, line_sync} = lvl;
endmodule
`default_nettype wire

// *** dv/sync_activity_detect_and_sync_outputs_test.sv ***
// self-checking bench for the sync activity block, register access over axi4-lite
// assumes syd_pkg and the partner source model are compiled first
`timescale 1ns/10ps
`default_nettype none
module sync_activity_detect_and_sync_outputs_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic power_down = 1'b0;
    logic [7:0] run_q = 8'h00;
    logic [7:0] inv_q = 8'h00;
    logic [11:0] period_q = 12'h064;
    logic [11:0] width_q = 12'h00A;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp, line_s, frame_s, green_s, tri_s;
    wire logic [31:0] s_axi_rdata;
    wire logic line_sync_out, frame_sync_out, line_start_marker, frame_marker;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;
    int n_errors = 0;
    int check_count = 0;
    int seed = 3;
    int per, mk, i;
    logic tri_seen;

    syd_sync_top #(.COMP_WINDOW_CYC(2000)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .line_sync_in(line_s), .frame_sync_in(frame_s),
        .green_embedded_sync_input(green_s), .trilevel_in(tri_s), .power_down(power_down),
        .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
        .line_start_marker(line_start_marker), .frame_marker(frame_marker)
    );

    syd_sync_src src (
        .aclk(aclk), .run(run_q), .inv(inv_q), .period(period_q), .width(width_q),
        .line_sync(line_s), .frame_sync(frame_s), .green_sync(green_s), .tri_sync(tri_s)
    );

    // 20 MHz
    initial
    begin
        forever #25 aclk = ~aclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        resp_q = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rdata_q = s_axi_rdata;
        resp_q = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // firmware source table walked top down, first match wins
    function automatic logic [31:0] fw_decide(input logic [31:0] st);
        if (st[0] && st[2]) return 32'h0;
        if (st[0]) return 32'h1;
        if (st[4] && st[6]) return 32'h2;
        if (st[4]) return 32'h3;
        return 32'h4;
    endfunction

    task automatic new_timing();
        per = 80 + ($unsigned($random(seed)) % 40);
        period_q <= 12'(per);
        width_q <= 12'(8 + ($unsigned($random(seed)) % 8));
    endtask

    // hang guard, well beyond the expected run
    initial
    begin
        repeat (80000) @(posedge aclk);
        n_errors++;
        test_done();
    end

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h10); check("slicer reset", rdata_q, 32'h16);
        rd(8'h14); check("incfg reset", rdata_q, 32'h0);
        rd(8'h04); check("status idle", rdata_q, 32'h0);
        rd(8'h0C); check("unmapped resp", 32'(resp_q), 32'(syd_pkg::RESP_SLVERR));
        wr(8'h04, 8'hFF); check("status wr resp", 32'(resp_q), 32'(syd_pkg::RESP_OKAY));
        rd(8'h04); check("status kept", rdata_q, 32'h0);
        wr(8'h10, 8'h16);
        // separate sync on ch0, inverted line on ch1
        new_timing();
        inv_q <= 8'h02;
        run_q <= 8'h07;
        repeat (3 * per) @(posedge aclk);
        rd(8'h04); check("status separate", rdata_q, 32'h07);
        check("decide separate", fw_decide(rdata_q), 32'h0);
        rd(8'h08); check("polarity", rdata_q, 32'h02);
        mk = 0;
        repeat (20 * per)
        begin
            @(posedge aclk);
            if (line_start_marker === 1'b1) mk++;
        end
        check("marker count", 32'(mk >= 19 && mk <= 21), 32'h1);
        // channel 1 in power down: copies live, markers quiet
        wr(8'h14, 8'h01);
        power_down <= 1'b1;
        repeat (4) @(posedge aclk);
        repeat (2 * per)
        begin
            @(negedge aclk);
            check("line copy", 32'(line_sync_out), 32'(line_s[1]));
            check("frame copy", 32'(frame_sync_out), 32'(frame_s[1]));
            check("markers off", {30'h0, line_start_marker, frame_marker}, 32'h0);
        end
        rd(8'h04); check("status power down", rdata_q, 32'h07);
        power_down <= 1'b0;
        wr(8'h14, 8'h00);
        run_q <= 8'h00;
        inv_q <= 8'h00;
        repeat (4100) @(posedge aclk);
        rd(8'h04); check("status cleared", rdata_q, 32'h0);
        check("decide none", fw_decide(rdata_q), 32'h4);
        // composite on line: long pulses at a slow rate
        period_q <= 12'd800;
        width_q <= 12'd300;
        run_q <= 8'h01;
        wr(8'h14, 8'h08);
        repeat (2420) @(posedge aclk);
        rd(8'h04); check("composite present", rdata_q, 32'h81);
        check("decide comp line", fw_decide(rdata_q), 32'h1);
        wr(8'h14, 8'h00);
        rd(8'h04); check("composite dropped", rdata_q, 32'h01);
        run_q <= 8'h00;
        repeat (4100) @(posedge aclk);
        // green with trilevel on ch0
        new_timing();
        wr(8'h14, 8'h10);
        run_q <= 8'h50;
        repeat (60 * per) @(posedge aclk);
        rd(8'h04); check("green early", 32'(rdata_q[4]), 32'h0);
        check("trilevel early", 32'(rdata_q[6]), 32'h1);
        repeat (12 * per) @(posedge aclk);
        tri_seen = 1'b0;
        for (i = 0; i < 3; i++)
        begin
            rd(8'h04);
            tri_seen = tri_seen | rdata_q[6];
        end
        check("green late", rdata_q, 32'h50);
        check("trilevel polled", 32'(tri_seen), 32'h1);
        check("decide green tri", fw_decide(rdata_q), 32'h2);
        repeat (per)
        begin
            @(negedge aclk);
            check("green copy", 32'(line_sync_out), 32'(green_s[0]));
        end
        test_done();
    end
endmodule
`default_nettype wire
